// File: src/bridge_window_status_consts.vh
// Constants for the bridge window and downstream status configuration registers.
// Assumes dword addresses are byte offsets of aligned configuration dwords.
`ifndef BRIDGE_WINDOW_STATUS_CONSTS_VH
`define BRIDGE_WINDOW_STATUS_CONSTS_VH

// ----------------------------------------------------------------
// Dword offsets
// ----------------------------------------------------------------
`define OFS_IO_WINDOW_DWORD 8'h1c
`define OFS_MEM_WINDOW_DWORD 8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IO_BOTTOM_IND_LSB 0
`define IO_BOTTOM_FIELD_LSB 4
`define IO_TOP_IND_LSB 8
`define IO_TOP_FIELD_LSB 12
`define STS_RSVD_LOW_LSB 16
`define STS_SPEED_BIT 21
`define STS_RSVD_HIGH_BIT 22
`define STS_FAST_B2B_BIT 23
`define STS_DATA_PAR_BIT 24
`define STS_DEVSEL_LSB 25
`define STS_SIG_TABORT_BIT 27
`define STS_RCV_TABORT_BIT 28
`define STS_RCV_MABORT_BIT 29
`define STS_RCV_SERR_BIT 30
`define STS_DET_PERR_BIT 31
`define MEM_BOTTOM_RSVD_LSB 0
`define MEM_BOTTOM_FIELD_LSB 4

// ----------------------------------------------------------------
// Fixed and reset values
// ----------------------------------------------------------------
`define IO_DECODE_32_IND 4'h1
`define MEM_BOTTOM_RSVD_VAL 4'h0
`define STS_FAST_B2B_VAL 1'b1
`define STS_DEVSEL_MEDIUM 2'h1
`define STS_RSVD_VAL 1'b0
`define IO_FIELD_RESET 4'h0
`define MEM_FIELD_RESET 12'h000
`define STATUS_RESET 6'h00
`define IO_LOW_ZERO 12'h000
`define MEM_LOW_ZERO 20'h00000

`endif

// File: src/status_w1c_bank.v
// Bank of six sticky status flags, cleared by writing one.
// Assumes set and clear strobes come from logic on the same clock.
`timescale 1ns/1ps
`include "bridge_window_status_consts.vh"

module status_w1c_bank (
  input wire clk,
  input wire srst,
  input wire [5:0] set_evt,
  input wire [5:0] clr_req,
  output wire [5:0] flags
);

  reg [5:0] flags_reg;
  wire [5:0] flags_next;

  // ----------------------------------------------------------------
  // Set wins over clear in the same cycle
  // ----------------------------------------------------------------
  assign flags_next = (flags_reg & ~clr_req) | set_evt;

  always @(posedge clk) begin
    if (srst) begin
      flags_reg <= `STATUS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

endmodule // status_w1c_bank

// File: src/bridge_window_status_regs.v
// Configuration dwords 0x1C and 0x20 of a PCI-to-PCI bridge: I/O window fields,
// downstream status flags and the memory window bottom field.
// Assumes configuration cycles arrive as one-cycle strobes on SYS_CLK, event
// inputs are same-clock pulses, and pin inputs are asynchronous.
//
// Summary of operation
// - I/O top register low nibble reads 1 for 32-bit I/O decoding.
// - Writable 4-bit field gives I/O top address bits 15:12, 4 kB granular.
// - Lower twelve I/O top address bits are zero, not stored.
// - Upper sixteen I/O address bits come from separate upper-half register input.
// - Writing 1 clears a status flag; writing 0 leaves it unchanged.
// - Reserved status bits 20:16 and 22 read zero.
// - 66-MHz capable bit reads the speed strap pin level.
// - Fast back-to-back capable bit always reads 1.
// - Data parity detected sets only as master with parity error and response enabled.
// - Device-select timing field reads constant 01b, medium timing.
// - Signaled target abort sets when target-aborting a downstream master.
// - Received target abort sets when mastering and target abort is received.
// - Received master abort sets when own downstream transaction master-aborts.
// - Received system error sets while downstream system error pin is asserted.
// - Detected parity error sets on downstream address or data parity error.
// - Memory window bottom low nibble is read-only zero.
// - Writable 12-bit field gives memory bottom bits 31:20, 1MB granular.
// - I/O bottom field resets to zero; its low nibble reads 1.
`timescale 1ns/1ps
`include "bridge_window_status_consts.vh"

module bridge_window_status_regs (
  input wire SYS_CLK,
  input wire SRST,
  input wire CFG_WR,
  input wire CFG_RD,
  input wire [7:0] CFG_ADDR,
  input wire [31:0] CFG_WDATA,
  input wire [3:0] UPSTREAM_BYTE_LANE_ENABLES_N,
  input wire [15:0] IO_BASE_UPPER,
  input wire [15:0] IO_LIMIT_UPPER,
  input wire SPEED_STRAP_PIN,
  input wire DOWNSTREAM_PARITY_ERROR_PIN_N,
  input wire DOWNSTREAM_SYSTEM_ERROR_PIN_N,
  input wire SEC_MASTER_ACTIVE,
  input wire PRI_PARITY_ERR,
  input wire PARITY_RESPONSE_EN,
  input wire SEC_TARGET_ABORT_SIGNALED,
  input wire SEC_TARGET_ABORT_RECEIVED,
  input wire SEC_MASTER_ABORT_RECEIVED,
  input wire SEC_ADDR_PARITY_ERR,
  input wire SEC_DATA_PARITY_ERR,
  output wire [31:0] CFG_RDATA,
  output wire CFG_RVALID,
  output wire CFG_HIT,
  output wire [31:0] IO_BASE_ADDR,
  output wire [31:0] IO_LIMIT_ADDR,
  output wire [31:0] MEM_BASE_ADDR,
  output wire SPEED_66_CAPABLE
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Byte lane enables are active low
  function lane_on;
    input [3:0] be_n;
    input [1:0] lane;
    begin
      lane_on = ~be_n[lane];
    end
  endfunction

  function dword_match;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      dword_match = (addr[7:2] == ofs[7:2]);
    end
  endfunction

  // Window address: upper half, 4-bit field, low twelve bits held at zero
  function [31:0] io_window_addr;
    input [15:0] upper;
    input [3:0] field;
    begin
      io_window_addr = {upper, field, `IO_LOW_ZERO};
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg [3:0] io_bottom_reg;
  reg [3:0] io_bottom_next;
  reg [3:0] io_top_reg;
  reg [3:0] io_top_next;
  reg [11:0] mem_bottom_reg;
  reg [11:0] mem_bottom_next;
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;
  reg rvalid_reg;
  reg hit_reg;
  reg hit_next;
  reg [31:0] io_base_addr_reg;
  reg [31:0] io_limit_addr_reg;
  reg [31:0] mem_base_addr_reg;

  reg strap_meta_reg;
  reg strap_sync_reg;
  reg perr_n_meta_reg;
  reg perr_n_sync_reg;
  reg serr_n_meta_reg;
  reg serr_n_sync_reg;

  wire sel_io;
  wire sel_mem;
  wire wr_io;
  wire wr_mem;
  wire wr_io_lane0;
  wire wr_io_lane1;
  wire wr_io_lane3;
  wire wr_mem_lane0;
  wire wr_mem_lane1;
  wire [5:0] status_set;
  reg [5:0] status_clr;
  wire [5:0] status_flags;
  reg [31:0] io_dword;
  reg [31:0] mem_dword;
  wire perr_seen;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Strap resets low so the capability bit claims nothing before the pin is seen;
  // error pins reset to their idle high level so leaving reset raises no event
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      strap_meta_reg <= 1'b0;
      strap_sync_reg <= 1'b0;
      perr_n_meta_reg <= 1'b1;
      perr_n_sync_reg <= 1'b1;
      serr_n_meta_reg <= 1'b1;
      serr_n_sync_reg <= 1'b1;
    end else begin
      strap_meta_reg <= SPEED_STRAP_PIN;
      strap_sync_reg <= strap_meta_reg;
      perr_n_meta_reg <= DOWNSTREAM_PARITY_ERROR_PIN_N;
      perr_n_sync_reg <= perr_n_meta_reg;
      serr_n_meta_reg <= DOWNSTREAM_SYSTEM_ERROR_PIN_N;
      serr_n_sync_reg <= serr_n_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign sel_io = dword_match(CFG_ADDR, `OFS_IO_WINDOW_DWORD);
  assign sel_mem = dword_match(CFG_ADDR, `OFS_MEM_WINDOW_DWORD);
  assign wr_io = CFG_WR & sel_io;
  assign wr_mem = CFG_WR & sel_mem;

  // ----------------------------------------------------------------
  // Per-lane write strobes
  // ----------------------------------------------------------------
  // A lane whose enable is high is left unwritten
  assign wr_io_lane0 = wr_io & lane_on(UPSTREAM_BYTE_LANE_ENABLES_N, 2'd0);
  assign wr_io_lane1 = wr_io & lane_on(UPSTREAM_BYTE_LANE_ENABLES_N, 2'd1);
  assign wr_io_lane3 = wr_io & lane_on(UPSTREAM_BYTE_LANE_ENABLES_N, 2'd3);
  assign wr_mem_lane0 = wr_mem & lane_on(UPSTREAM_BYTE_LANE_ENABLES_N, 2'd0);
  assign wr_mem_lane1 = wr_mem & lane_on(UPSTREAM_BYTE_LANE_ENABLES_N, 2'd1);

  // ----------------------------------------------------------------
  // Writable window fields
  // ----------------------------------------------------------------
  always @* begin
    io_bottom_next = io_bottom_reg;
    io_top_next = io_top_reg;
    mem_bottom_next = mem_bottom_reg;
    if (wr_io_lane0) begin
      io_bottom_next = CFG_WDATA[`IO_BOTTOM_FIELD_LSB +: 4];
    end
    if (wr_io_lane1) begin
      io_top_next = CFG_WDATA[`IO_TOP_FIELD_LSB +: 4];
    end
    if (wr_mem_lane0) begin
      mem_bottom_next[3:0] = CFG_WDATA[`MEM_BOTTOM_FIELD_LSB +: 4];
    end
    if (wr_mem_lane1) begin
      mem_bottom_next[11:4] = CFG_WDATA[`MEM_BOTTOM_FIELD_LSB + 4 +: 8];
    end
  end

  // ----------------------------------------------------------------
  // Window field registers
  // ----------------------------------------------------------------

  always @(posedge SYS_CLK) begin
    if (SRST) begin
      io_bottom_reg <= `IO_FIELD_RESET;
      io_top_reg <= `IO_FIELD_RESET;
      mem_bottom_reg <= `MEM_FIELD_RESET;
    end else begin
      io_bottom_reg <= io_bottom_next;
      io_top_reg <= io_top_next;
      mem_bottom_reg <= mem_bottom_next;
    end
  end

  // ----------------------------------------------------------------
  // Status event sources
  // ----------------------------------------------------------------
  assign perr_seen = ~perr_n_sync_reg | PRI_PARITY_ERR;

  // Bank order: data parity, signaled TA, received TA, received MA,
  // received system error, detected parity error
  // Received target abort counts only while this side is master on the bus
  assign status_set[0] = SEC_MASTER_ACTIVE & perr_seen & PARITY_RESPONSE_EN;
  assign status_set[1] = SEC_TARGET_ABORT_SIGNALED;
  assign status_set[2] = SEC_TARGET_ABORT_RECEIVED & SEC_MASTER_ACTIVE;
  assign status_set[3] = SEC_MASTER_ABORT_RECEIVED;
  assign status_set[4] = ~serr_n_sync_reg;
  assign status_set[5] = SEC_ADDR_PARITY_ERR | SEC_DATA_PARITY_ERR;

  // ----------------------------------------------------------------
  // Status clear terms
  // ----------------------------------------------------------------
  // Only byte lane 3 carries write-one-to-clear flags
  always @* begin
    status_clr = 6'h00;
    if (wr_io_lane3) begin
      status_clr[0] = CFG_WDATA[`STS_DATA_PAR_BIT];
      status_clr[1] = CFG_WDATA[`STS_SIG_TABORT_BIT];
      status_clr[2] = CFG_WDATA[`STS_RCV_TABORT_BIT];
      status_clr[3] = CFG_WDATA[`STS_RCV_MABORT_BIT];
      status_clr[4] = CFG_WDATA[`STS_RCV_SERR_BIT];
      status_clr[5] = CFG_WDATA[`STS_DET_PERR_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Status flag bank
  // ----------------------------------------------------------------
  // Set wins over a clear in the same cycle, so no event is lost
  status_w1c_bank u_status (
    .clk(SYS_CLK),
    .srst(SRST),
    .set_evt(status_set),
    .clr_req(status_clr),
    .flags(status_flags)
  );

  // ----------------------------------------------------------------
  // Dword 0x1C composition
  // ----------------------------------------------------------------
  always @* begin
    io_dword = 32'h00000000;
    io_dword[`IO_BOTTOM_IND_LSB +: 4] = `IO_DECODE_32_IND;
    io_dword[`IO_BOTTOM_FIELD_LSB +: 4] = io_bottom_reg;
    io_dword[`IO_TOP_IND_LSB +: 4] = `IO_DECODE_32_IND;
    io_dword[`IO_TOP_FIELD_LSB +: 4] = io_top_reg;
    io_dword[`STS_RSVD_LOW_LSB +: 5] = 5'h00;
    io_dword[`STS_SPEED_BIT] = strap_sync_reg;
    io_dword[`STS_RSVD_HIGH_BIT] = `STS_RSVD_VAL;
    io_dword[`STS_FAST_B2B_BIT] = `STS_FAST_B2B_VAL;
    io_dword[`STS_DATA_PAR_BIT] = status_flags[0];
    io_dword[`STS_DEVSEL_LSB +: 2] = `STS_DEVSEL_MEDIUM;
    io_dword[`STS_SIG_TABORT_BIT] = status_flags[1];
    io_dword[`STS_RCV_TABORT_BIT] = status_flags[2];
    io_dword[`STS_RCV_MABORT_BIT] = status_flags[3];
    io_dword[`STS_RCV_SERR_BIT] = status_flags[4];
    io_dword[`STS_DET_PERR_BIT] = status_flags[5];
  end

  // ----------------------------------------------------------------
  // Dword 0x20 composition
  // ----------------------------------------------------------------
  // Upper half of this dword belongs to another block and reads zero here
  always @* begin
    mem_dword = 32'h00000000;
    mem_dword[`MEM_BOTTOM_RSVD_LSB +: 4] = `MEM_BOTTOM_RSVD_VAL;
    mem_dword[`MEM_BOTTOM_FIELD_LSB +: 12] = mem_bottom_reg;
  end

  // ----------------------------------------------------------------
  // Read response
  // ----------------------------------------------------------------
  // A read returns the values from before a write taken on the same edge

  always @* begin
    rdata_next = 32'h00000000;
    hit_next = 1'b0;
    if (CFG_RD || CFG_WR) begin
      hit_next = sel_io | sel_mem;
    end
    if (CFG_RD && sel_io) begin
      rdata_next = io_dword;
    end else if (CFG_RD && sel_mem) begin
      rdata_next = mem_dword;
    end
  end

  // ----------------------------------------------------------------
  // Read response registers
  // ----------------------------------------------------------------
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      rdata_reg <= 32'h00000000;
      rvalid_reg <= 1'b0;
      hit_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= CFG_RD;
      hit_reg <= hit_next;
    end
  end

  // ----------------------------------------------------------------
  // Forwarding window addresses
  // ----------------------------------------------------------------
  // Window addresses follow the fields one cycle later
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      io_base_addr_reg <= 32'h00000000;
      io_limit_addr_reg <= 32'h00000000;
      mem_base_addr_reg <= 32'h00000000;
    end else begin
      io_base_addr_reg <= io_window_addr(IO_BASE_UPPER, io_bottom_reg);
      io_limit_addr_reg <= io_window_addr(IO_LIMIT_UPPER, io_top_reg);
      mem_base_addr_reg <= {mem_bottom_reg, `MEM_LOW_ZERO};
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign CFG_RDATA = rdata_reg;
  assign CFG_RVALID = rvalid_reg;
  assign CFG_HIT = hit_reg;
  assign IO_BASE_ADDR = io_base_addr_reg;
  assign IO_LIMIT_ADDR = io_limit_addr_reg;
  assign MEM_BASE_ADDR = mem_base_addr_reg;
  assign SPEED_66_CAPABLE = strap_sync_reg;

endmodule // bridge_window_status_regs

// File: tb/bridge_regs_properties.sv
// Port assertions for the bridge window and downstream status registers.
// Assumes SYS_CLK only and synchronous active-high SRST.
`timescale 1ns/1ps
module bridge_regs_checker (
  input wire SYS_CLK,
  input wire SRST,
  input wire CFG_WR,
  input wire CFG_RD,
  input wire [7:0] CFG_ADDR,
  input wire [31:0] CFG_WDATA,
  input wire [3:0] UPSTREAM_BYTE_LANE_ENABLES_N,
  input wire [15:0] IO_LIMIT_UPPER,
  input wire SEC_MASTER_ACTIVE,
  input wire SEC_TARGET_ABORT_RECEIVED,
  input wire SEC_MASTER_ABORT_RECEIVED,
  input wire SPEED_66_CAPABLE,
  input wire [31:0] CFG_RDATA,
  input wire CFG_RVALID,
  input wire CFG_HIT,
  input wire [31:0] IO_LIMIT_ADDR,
  input wire [31:0] MEM_BASE_ADDR
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  wire [3:0] ben = UPSTREAM_BYTE_LANE_ENABLES_N;
  wire any_hit = CFG_ADDR[7:2] == 6'h07 || CFG_ADDR[7:2] == 6'h08;
  wire rd_io = CFG_RD && CFG_ADDR[7:2] == 6'h07;
  wire rd_mem = CFG_RD && CFG_ADDR[7:2] == 6'h08;
  wire wr_io = CFG_WR && CFG_ADDR[7:2] == 6'h07;
  wire clr29 = wr_io && !ben[3] && CFG_WDATA[29];
  a_io_ind_one: assert property (rd_io |=> CFG_RDATA[11:8] == 4'h1 && CFG_RDATA[3:0] == 4'h1)
    else $error("I/O decode indicator wrong");
  a_sts_fixed_bits: assert property (rd_io |=> CFG_RDATA[26:25] == 2'b01 && CFG_RDATA[23]
    && CFG_RDATA[22] == 1'b0 && CFG_RDATA[20:16] == 5'h00) else $error("fixed status bits wrong");
  a_speed_bit: assert property (rd_io |=> CFG_RDATA[21] == $past(SPEED_66_CAPABLE))
    else $error("speed bit differs from strap");
  a_mem_low_zero: assert property (rd_mem |=> CFG_RDATA[3:0] == 4'h0 && CFG_RDATA[31:16] == 16'h0)
    else $error("memory dword read-only bits not zero");
  a_mem_base_addr: assert property (CFG_WR && CFG_ADDR[7:2] == 6'h08 && ben[1:0] == 2'b00
    |-> ##2 MEM_BASE_ADDR == {$past(CFG_WDATA[15:4], 2), 20'h00000}) else $error("memory base wrong");
  a_io_top_addr: assert property (wr_io && !ben[1] |-> ##2 IO_LIMIT_ADDR ==
    {$past(IO_LIMIT_UPPER), $past(CFG_WDATA[15:12], 2), 12'h000}) else $error("I/O top wrong");
  a_w1c_clears: assert property (clr29 && !SEC_MASTER_ABORT_RECEIVED ##1
    !SEC_MASTER_ABORT_RECEIVED ##1 rd_io |=> !CFG_RDATA[29]) else $error("flag not cleared");
  a_mabort_sets: assert property (SEC_MASTER_ABORT_RECEIVED ##1 !clr29 ##1 rd_io
    |=> CFG_RDATA[29]) else $error("master abort flag not set");
  a_rta_gated: assert property (SEC_TARGET_ABORT_RECEIVED && SEC_MASTER_ACTIVE ##1 !wr_io
    ##1 rd_io |=> CFG_RDATA[28]) else $error("target abort flag not set");
  a_bus_answer: assert property ((CFG_RD || CFG_WR) |=> CFG_HIT == $past(any_hit)
    && CFG_RVALID == $past(CFG_RD)) else $error("bus answer wrong");
  c_flag_read: cover property (rd_io ##1 CFG_RDATA[31]);
  c_clear_read: cover property (clr29 ##2 rd_io);
  c_unmapped: cover property (CFG_RD && !any_hit);
  c_set_beats_clear: cover property (clr29 && SEC_MASTER_ABORT_RECEIVED);
endmodule // bridge_regs_checker

bind bridge_window_status_regs bridge_regs_checker i_chk (
  .SYS_CLK(SYS_CLK), .SRST(SRST), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD), .CFG_ADDR(CFG_ADDR),
  .CFG_WDATA(CFG_WDATA), .UPSTREAM_BYTE_LANE_ENABLES_N(UPSTREAM_BYTE_LANE_ENABLES_N),
  .IO_LIMIT_UPPER(IO_LIMIT_UPPER), .SEC_MASTER_ACTIVE(SEC_MASTER_ACTIVE),
  .SEC_TARGET_ABORT_RECEIVED(SEC_TARGET_ABORT_RECEIVED), .SPEED_66_CAPABLE(SPEED_66_CAPABLE),
  .SEC_MASTER_ABORT_RECEIVED(SEC_MASTER_ABORT_RECEIVED), .CFG_RDATA(CFG_RDATA),
  .CFG_RVALID(CFG_RVALID), .CFG_HIT(CFG_HIT), .IO_LIMIT_ADDR(IO_LIMIT_ADDR),
  .MEM_BASE_ADDR(MEM_BASE_ADDR)
);

// File: tb/cfg_host_model.sv
// Configuration master issuing single read and write cycles.
// Assumes the caller runs on the same clock; requests move 1 ns after an edge.
`timescale 1ns/1ps
module cfg_host_model (
  input wire clk,
  input wire [31:0] rdata,
  input wire rvalid,
  input wire hit,
  output reg wr,
  output reg rd,
  output reg [7:0] addr,
  output reg [31:0] wdata,
  output reg [3:0] be_n
);
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    be_n = 4'hf;
  end
  // Released lines flip so stale values never look valid
  task wr_cycle(input [7:0] a, input [3:0] b, input [31:0] d, output h);
    @(posedge clk);
    #1;
    wr = 1'b1;
    addr = a;
    be_n = b;
    wdata = d;
    @(posedge clk);
    #1;
    h = hit;
    wr = 1'b0;
    be_n = 4'hf;
    addr = ~addr;
    wdata = ~wdata;
  endtask
  task rd_cycle(input [7:0] a, output [31:0] d, output v, output h);
    @(posedge clk);
    #1;
    rd = 1'b1;
    addr = a;
    @(posedge clk);
    #1;
    d = rdata;
    v = rvalid;
    h = hit;
    rd = 1'b0;
    addr = ~addr;
  endtask
endmodule // cfg_host_model

// File: tb/tb_top.sv
// Self-checking bench for the bridge window and downstream status registers.
// Assumes the design under src/ and the host model and checker under tb/.
`timescale 1ns/1ps
module tb_top;
  localparam [31:0] STS0 = 32'h02a0_0101;
  localparam [31:0] STSW = 32'h02a0_a151;
  reg sys_clk, srst, strap, perr_n, serr_n, mst, resp_en, v, h;
  reg [5:0] evt;
  reg [31:0] d;
  reg [15:0] lim_up;
  wire wr, rd, rvalid, hit, spd;
  wire [7:0] addr;
  wire [3:0] be_n;
  wire [31:0] wdata, rdata, io_base, io_lim, mem_base;
  integer n_mismatch, n_tests;
  cfg_host_model i_host (.clk(sys_clk), .rdata(rdata), .rvalid(rvalid), .hit(hit), .wr(wr),
    .rd(rd), .addr(addr), .wdata(wdata), .be_n(be_n));
  bridge_window_status_regs i_dut (.SYS_CLK(sys_clk), .SRST(srst), .CFG_WR(wr), .CFG_RD(rd),
    .CFG_ADDR(addr), .CFG_WDATA(wdata), .UPSTREAM_BYTE_LANE_ENABLES_N(be_n),
    .IO_BASE_UPPER(16'h1234), .IO_LIMIT_UPPER(lim_up), .SPEED_STRAP_PIN(strap),
    .DOWNSTREAM_PARITY_ERROR_PIN_N(perr_n), .DOWNSTREAM_SYSTEM_ERROR_PIN_N(serr_n),
    .SEC_MASTER_ACTIVE(mst), .PRI_PARITY_ERR(evt[5]), .PARITY_RESPONSE_EN(resp_en),
    .SEC_TARGET_ABORT_SIGNALED(evt[0]), .SEC_TARGET_ABORT_RECEIVED(evt[1]),
    .SEC_MASTER_ABORT_RECEIVED(evt[2]), .SEC_ADDR_PARITY_ERR(evt[3]),
    .SEC_DATA_PARITY_ERR(evt[4]), .CFG_RDATA(rdata), .CFG_RVALID(rvalid), .CFG_HIT(hit),
    .IO_BASE_ADDR(io_base), .IO_LIMIT_ADDR(io_lim), .MEM_BASE_ADDR(mem_base),
    .SPEED_66_CAPABLE(spd));
  task chk(input string nm, input [31:0] e, input [31:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_mismatch = n_mismatch + 1;
    end
  endtask
  task rdx(input [7:0] a, input [31:0] e, input string nm);
    i_host.rd_cycle(a, d, v, h);
    chk(nm, e, d);
    chk("read valid", 32'h1, {31'h0, v});
    chk("read hit", (a == 8'h24) ? 32'h0 : 32'h1, {31'h0, h});
  endtask
  task wait_cyc(input integer n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task pulse(input integer i);
    @(posedge sys_clk);
    #1;
    evt[i] = 1'b1;
    @(posedge sys_clk);
    #1;
    evt = 6'h00;
  endtask
  task t_reset;
    rdx(8'h1c, STS0, "dword 1c");
    rdx(8'h20, 32'h0, "dword 20");
    chk("mem base", 32'h0, mem_base);
    chk("io limit", 32'h5678_0000, io_lim);
    strap = 1'b0;
    wait_cyc(4);
    rdx(8'h1c, 32'h0280_0101, "strap low");
    chk("speed out low", 32'h0, {31'h0, spd});
    strap = 1'b1;
    wait_cyc(4);
    chk("speed out high", 32'h1, {31'h0, spd});
    $display("reset and strap test done");
  endtask
  task t_windows;
    i_host.wr_cycle(8'h1c, 4'hc, 32'hffff_af5f, h);
    chk("write hit", 32'h1, {31'h0, h});
    rdx(8'h1c, STSW, "io fields");
    chk("io limit", 32'h5678_a000, io_lim);
    chk("io base", 32'h1234_5000, io_base);
    lim_up = 16'h9abc;
    wait_cyc(2);
    chk("io limit upper", 32'h9abc_a000, io_lim);
    lim_up = 16'h5678;
    i_host.wr_cycle(8'h20, 4'h0, 32'hffff_abcf, h);
    rdx(8'h20, 32'h0000_abc0, "mem field");
    chk("mem base", 32'habc0_0000, mem_base);
    i_host.wr_cycle(8'h20, 4'he, 32'h0000_0010, h);
    i_host.wr_cycle(8'h24, 4'h0, 32'hffff_ffff, h);
    chk("unmapped hit", 32'h0, {31'h0, h});
    rdx(8'h24, 32'h0, "unmapped read");
    rdx(8'h20, 32'h0000_ab10, "lane 0 only");
    $display("window test done");
  endtask
  task t_events;
    integer i;
    reg [31:0] b;
    mst = 1'b1;
    for (i = 0; i < 5; i = i + 1) begin
      b = 32'h1 << ((i < 3) ? 27 + i : 31);
      pulse(i);
      rdx(8'h1c, STSW | b, "event flag");
      i_host.wr_cycle(8'h1c, 4'h7, 32'h0, h);
      rdx(8'h1c, STSW | b, "zero write");
      i_host.wr_cycle(8'h1c, 4'h7, b, h);
      rdx(8'h1c, STSW, "flag cleared");
    end
    mst = 1'b0;
    pulse(1);
    rdx(8'h1c, STSW, "abort as target");
    $display("event test done");
  endtask
  task t_parity;
    integer i;
    for (i = 0; i < 4; i = i + 1) begin
      {mst, resp_en} = i[1:0];
      pulse(5);
      rdx(8'h1c, STSW | ((i == 3) ? 32'h0100_0000 : 32'h0), "parity gate");
      i_host.wr_cycle(8'h1c, 4'h7, 32'h0100_0000, h);
    end
    perr_n = 1'b0;
    serr_n = 1'b0;
    wait_cyc(4);
    perr_n = 1'b1;
    serr_n = 1'b1;
    wait_cyc(4);
    rdx(8'h1c, STSW | 32'h4100_0000, "pin flags");
    i_host.wr_cycle(8'h1c, 4'h7, 32'h4100_0000, h);
    rdx(8'h1c, STSW, "pin flags cleared");
    fork
      i_host.wr_cycle(8'h1c, 4'h7, 32'h2000_0000, h);
      pulse(2);
    join
    rdx(8'h1c, STSW | 32'h2000_0000, "set beats clear");
    $display("parity and collision test done");
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    close_out;
  end
  initial begin
    {srst, strap, perr_n, serr_n, mst, resp_en, evt} = 12'hfc0;
    lim_up = 16'h5678;
    n_mismatch = 0;
    n_tests = 0;
    wait_cyc(4);
    srst = 1'b0;
    wait_cyc(3);
    t_reset;
    t_windows;
    t_events;
    t_parity;
    srst = 1'b1;
    wait_cyc(2);
    srst = 1'b0;
    wait_cyc(3);
    t_reset;
    close_out;
  end
endmodule // tb_top
